// ### logic/sdimd_defines.vh
// constants for the sdi mode and transport lock detector
`ifndef SDIMD_DEFINES_VH
`define SDIMD_DEFINES_VH
`define SDIMD_REG_CTRL 8'h00
`define SDIMD_REG_STAT 8'h04
`define SDIMD_REG_ERR 8'h08
`define SDIMD_CTRL_EN_RST 6'h3F
`define SDIMD_CTRL_FRM_BIT 8
`define SDIMD_LOCK_LINES 4'h3
`define SDIMD_LOSS_LINES 4'hF
`define SDIMD_TRS_ONES 10'h3FF
`define SDIMD_TRS_ZERO 10'h000
`define SDIMD_NUM_MODES 3'h6
`define SDIMD_M_HD 3'h0
`define SDIMD_M_SD 3'h1
`define SDIMD_M_3G 3'h2
`define SDIMD_M_6G 3'h4
`define SDIMD_M_12GA 3'h5
`define SDIMD_M_12GB 3'h6
`define SDIMD_FAM_1080 4'h0
`define SDIMD_FAM_720 4'h1
`define SDIMD_FAM_525 4'h2
`define SDIMD_FAM_625 4'h3
`define SDIMD_FAM_2160 4'h4
`define SDIMD_FAM_NONE 4'hF
`define SDIMD_LINES_1080 12'h465
`define SDIMD_LINES_720 12'h2EE
`define SDIMD_LINES_525 12'h20D
`define SDIMD_LINES_625 12'h271
`define SDIMD_LINES_2160 12'h8CA
`define SDIMD_RATE_60 4'h1
`define SDIMD_RATE_50 4'h2
`define SDIMD_RATE_30 4'h3
`define SDIMD_RATE_25 4'h4
`define SDIMD_RATE_24 4'h5
`define SDIMD_RATE_NONE 4'hF
`define SDIMD_THR_60_50 24'h37F2AA
`define SDIMD_THR_50_30 24'h516155
`define SDIMD_THR_30_25 24'h6FE2AA
`define SDIMD_THR_25_24 24'h7C9ABA
`define SDIMD_THR_24_MAX 24'h8339EB
`endif

// ### logic/sdimd_lock.v
// sdi mode hunt, mode lock, transport detect and apb status slave
// What this block does
// - lock is declared only after three consecutive good lines (valid xyz, no crc error).
// - with all modes enabled the hunt steps hd, 3g, 6g, 12g a, 12g b, sd, then hd again.
// - only modes whose enable bit is set are searched; all six enable bits are set at reset.
// - the three-bit mode output shows the rate mode now being searched or, once locked, received.
// - lock drops after 15 or more consecutive bad lines.
// - after lock drops the hunt restarts and repeats until lock returns.
// - transport format is taken over two frames, then family, rate and scan are shown.
// - eav, sav and trs pulses come one cycle after the xyz word of each trs with valid protection bits.
// - line crc errors are reported per stream, streams 1 to 16.
`timescale 1ns/1ps
`default_nettype none
`include "sdimd_defines.vh"
module sdimd_lock #(
  parameter LINE_TIMEOUT = 16384
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [9:0] rx_word,
  input wire [15:0] stream_crc_bad,
  input wire stream_crc_stb,
  output reg [2:0] rx_mode,
  output reg mode_locked,
  output reg t_locked,
  output reg [3:0] t_family,
  output reg [3:0] t_rate,
  output reg t_scan,
  output reg eav_pulse,
  output reg sav_pulse,
  output reg trs_pulse,
  output reg [15:0] line_check_error_stream
);
  localparam ST_HUNT = 1'b0, ST_LOCK = 1'b1;
  reg [5:0] mode_en_q;
  reg frame_en_q, state_q, eav_seen_q, eav_ok_q, meas_q, ilace_q, v_q;
  reg [2:0] idx_q;
  reg [3:0] good_q, bad_q;
  reg [15:0] tmo_q;
  reg [11:0] lines_q, prev_lines_q;
  reg [23:0] fcyc_q;
  wire trs_hit, xyz_ok, is_eav, f_bit, v_bit, good_line, bad_line;
  wire timeout, eav_ev, frame_ev, apb_setup, apb_wr;

  // search order index to mode code
  function [2:0] idx_mode;
    input [2:0] i;
    begin
      case (i)
        3'h0: idx_mode = `SDIMD_M_HD;
        3'h1: idx_mode = `SDIMD_M_3G;
        3'h2: idx_mode = `SDIMD_M_6G;
        3'h3: idx_mode = `SDIMD_M_12GA;
        3'h4: idx_mode = `SDIMD_M_12GB;
        3'h5: idx_mode = `SDIMD_M_SD;
        default: idx_mode = `SDIMD_M_HD;
      endcase
    end
  endfunction
  // first enabled index at or after start, wrapping; stays put if none enabled
  function [2:0] next_idx;
    input [2:0] start;
    input [5:0] en;
    input [2:0] hold;
    integer k;
    reg [2:0] c;
    reg found;
    begin
      next_idx = hold;
      found = 1'b0;
      c = start;
      for (k = 0; k < `SDIMD_NUM_MODES; k = k + 1) begin
        if (!found && en[c]) begin
          next_idx = c;
          found = 1'b1;
        end
        c = (c == `SDIMD_NUM_MODES - 3'h1) ? 3'h0 : c + 3'h1;
      end
    end
  endfunction
  function [3:0] fam_of;
    input [11:0] n;
    begin
      case (n)
        `SDIMD_LINES_1080: fam_of = `SDIMD_FAM_1080;
        `SDIMD_LINES_720: fam_of = `SDIMD_FAM_720;
        `SDIMD_LINES_525: fam_of = `SDIMD_FAM_525;
        `SDIMD_LINES_625: fam_of = `SDIMD_FAM_625;
        `SDIMD_LINES_2160: fam_of = `SDIMD_FAM_2160;
        default: fam_of = `SDIMD_FAM_NONE;
      endcase
    end
  endfunction
  // thresholds sit midway between nominal frame periods at 200 mhz
  function [3:0] rate_of;
    input [23:0] c;
    begin
      if (c < `SDIMD_THR_60_50) rate_of = `SDIMD_RATE_60;
      else if (c < `SDIMD_THR_50_30) rate_of = `SDIMD_RATE_50;
      else if (c < `SDIMD_THR_30_25) rate_of = `SDIMD_RATE_30;
      else if (c < `SDIMD_THR_25_24) rate_of = `SDIMD_RATE_25;
      else if (c < `SDIMD_THR_24_MAX) rate_of = `SDIMD_RATE_24;
      else rate_of = `SDIMD_RATE_NONE;
    end
  endfunction
  sdimd_trs_scan u_scan (
    .pclk(pclk),
    .presetn(presetn),
    .word(rx_word),
    .trs_hit(trs_hit),
    .xyz_ok(xyz_ok),
    .is_eav(is_eav),
    .f_bit(f_bit),
    .v_bit(v_bit)
  );
  assign eav_ev = frame_en_q && trs_hit && xyz_ok && is_eav;
  assign frame_ev = eav_ev && v_bit && !v_q && !f_bit;
  assign good_line = frame_en_q && stream_crc_stb && eav_seen_q && eav_ok_q &&
                     (stream_crc_bad == 16'h0000);
  assign bad_line = frame_en_q && stream_crc_stb && !good_line;
  assign timeout = frame_en_q && (tmo_q == LINE_TIMEOUT[15:0] - 16'h0001);
  assign apb_setup = psel && !penable && !pready;
  assign apb_wr = psel && penable && pready && pwrite;
  // apb slave: no wait states, answer at the first access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      mode_en_q <= `SDIMD_CTRL_EN_RST;
      frame_en_q <= 1'b1;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        case (paddr)
          `SDIMD_REG_CTRL: prdata <= {23'h000000, frame_en_q, 2'h0, mode_en_q};
          `SDIMD_REG_STAT: prdata <= {18'h00000, t_scan, t_rate, t_family, t_locked,
                                      mode_locked, rx_mode};
          `SDIMD_REG_ERR: prdata <= {16'h0000, line_check_error_stream};
          default: pslverr <= 1'b1;
        endcase
      end
      if (apb_wr && paddr == `SDIMD_REG_CTRL) begin
        mode_en_q <= pwdata[5:0];
        frame_en_q <= pwdata[`SDIMD_CTRL_FRM_BIT];
      end
    end
  end
  // mode hunt and lock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_HUNT;
      idx_q <= 3'h0;
      good_q <= 4'h0;
      bad_q <= 4'h0;
      tmo_q <= 16'h0000;
      eav_seen_q <= 1'b0;
      eav_ok_q <= 1'b0;
      rx_mode <= `SDIMD_M_HD;
      mode_locked <= 1'b0;
    end else begin
      // mode output follows the searched or locked mode
      rx_mode <= idx_mode(idx_q);
      mode_locked <= (state_q == ST_LOCK);
      if (frame_en_q && trs_hit && is_eav) begin
        eav_seen_q <= 1'b1;
        eav_ok_q <= xyz_ok;
      end else if (stream_crc_stb) begin
        eav_seen_q <= 1'b0;
      end
      if (!frame_en_q || stream_crc_stb || timeout) begin
        tmo_q <= 16'h0000;
      end else begin
        tmo_q <= tmo_q + 16'h0001;
      end
      case (state_q)
        ST_HUNT: begin
          if (good_line) begin
            // three good lines in a row
            if (good_q == `SDIMD_LOCK_LINES - 4'h1) begin
              state_q <= ST_LOCK;
              good_q <= 4'h0;
              bad_q <= 4'h0;
            end else begin
              good_q <= good_q + 4'h1;
            end
          end else if (bad_line) begin
            good_q <= 4'h0;
          end else if (timeout || !mode_en_q[idx_q]) begin
            good_q <= 4'h0;
            idx_q <= next_idx((idx_q == `SDIMD_NUM_MODES - 3'h1) ? 3'h0 : idx_q + 3'h1,
                              mode_en_q, idx_q);
          end
        end
        ST_LOCK: begin
          if (good_line) begin
            bad_q <= 4'h0;
          end else if (bad_line || timeout) begin
            if (bad_q == `SDIMD_LOSS_LINES - 4'h1) begin
              state_q <= ST_HUNT;
              bad_q <= 4'h0;
              // rescan from the head of the order
              idx_q <= next_idx(3'h0, mode_en_q, idx_q);
            end else begin
              bad_q <= bad_q + 4'h1;
            end
          end
        end
        default: state_q <= ST_HUNT;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eav_pulse <= 1'b0;
      sav_pulse <= 1'b0;
      trs_pulse <= 1'b0;
      line_check_error_stream <= 16'h0000;
    end else begin
      trs_pulse <= frame_en_q && trs_hit && xyz_ok;
      eav_pulse <= eav_ev;
      sav_pulse <= frame_en_q && trs_hit && xyz_ok && !is_eav;
      if (stream_crc_stb) begin
        line_check_error_stream <= stream_crc_bad;
      end
    end
  end

  // transport format: needs a start boundary plus two equal frames
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines_q <= 12'h000;
      prev_lines_q <= 12'h000;
      fcyc_q <= 24'h000000;
      meas_q <= 1'b0;
      ilace_q <= 1'b0;
      v_q <= 1'b0;
      t_locked <= 1'b0;
      t_family <= `SDIMD_FAM_NONE;
      t_rate <= `SDIMD_RATE_NONE;
      t_scan <= 1'b0;
    end else if (state_q != ST_LOCK) begin
      meas_q <= 1'b0;
      t_locked <= 1'b0;
      lines_q <= 12'h000;
      fcyc_q <= 24'h000000;
    end else begin
      // saturate so a stalled input cannot wrap into a valid rate
      if (fcyc_q != 24'hFFFFFF) begin
        fcyc_q <= fcyc_q + 24'h000001;
      end
      if (eav_ev) begin
        v_q <= v_bit;
      end
      if (frame_ev) begin
        prev_lines_q <= lines_q + 12'h001;
        meas_q <= 1'b1;
        lines_q <= 12'h000;
        fcyc_q <= 24'h000000;
        ilace_q <= 1'b0;
        if (meas_q && (lines_q + 12'h001 == prev_lines_q)) begin
          t_locked <= 1'b1;
          t_family <= fam_of(prev_lines_q);
          t_rate <= rate_of(fcyc_q);
          t_scan <= ilace_q;
        end else begin
          t_locked <= 1'b0;
        end
      end else if (eav_ev) begin
        lines_q <= lines_q + 12'h001;
        if (f_bit) begin
          ilace_q <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/sdimd_trs_scan.v
// trs symbol finder with xyz protection check
`timescale 1ns/1ps
`default_nettype none
`include "sdimd_defines.vh"
module sdimd_trs_scan (
  input wire pclk,
  input wire presetn,
  input wire [9:0] word,
  output wire trs_hit,
  output wire xyz_ok,
  output wire is_eav,
  output wire f_bit,
  output wire v_bit
);
  reg [9:0] w1_q;
  reg [9:0] w2_q;
  reg [9:0] w3_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w1_q <= 10'h000;
      w2_q <= 10'h000;
      w3_q <= 10'h000;
    end else begin
      w1_q <= word;
      w2_q <= w1_q;
      w3_q <= w2_q;
    end
  end
  // preamble 3ff 000 000, current word is xyz
  assign trs_hit = (w3_q == `SDIMD_TRS_ONES) && (w2_q == `SDIMD_TRS_ZERO) &&
                   (w1_q == `SDIMD_TRS_ZERO);
  assign f_bit = word[8];
  assign v_bit = word[7];
  assign is_eav = word[6];
  // protection bits must match f, v, h
  assign xyz_ok = word[9] && (word[1:0] == 2'h0) &&
                  (word[5] == (word[7] ^ word[6])) &&
                  (word[4] == (word[8] ^ word[6])) &&
                  (word[3] == (word[8] ^ word[7])) &&
                  (word[2] == (word[8] ^ word[7] ^ word[6]));
endmodule
`default_nettype wire

// ### test/sdimd_lock_checker.sv
// port checker for the sdi mode lock detector
`timescale 1ns/1ps
`default_nettype none
module sdimd_lock_checker #(
  parameter LINE_TIMEOUT = 16384
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [9:0] rx_word,
  input wire logic [15:0] stream_crc_bad,
  input wire logic stream_crc_stb,
  input wire logic [2:0] rx_mode,
  input wire logic mode_locked,
  input wire logic t_locked,
  input wire logic [3:0] t_family,
  input wire logic eav_pulse,
  input wire logic sav_pulse,
  input wire logic trs_pulse,
  input wire logic [15:0] line_check_error_stream
);
  logic [29:0] hist_q;
  logic [3:0] bad_q;
  logic [1:0] good_q;
  wire logic [2:0] fvh = rx_word[8:6];
  wire logic hit = hist_q == 30'h3FF00000 && rx_word == {1'b1, fvh, fvh[1] ^ fvh[0],
    fvh[2] ^ fvh[0], fvh[2] ^ fvh[1], ^fvh, 2'b00};
  wire logic good = stream_crc_stb && stream_crc_bad == 16'h0000;
  // runs saturate so a long outage cannot wrap below the limits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_q <= 30'h0;
      bad_q <= 4'h0;
      good_q <= 2'h0;
    end else begin
      hist_q <= {hist_q[19:0], rx_word};
      if (good) begin
        bad_q <= 4'h0;
        good_q <= (good_q == 2'h3) ? 2'h3 : good_q + 2'h1;
      end else if (stream_crc_stb) begin
        good_q <= 2'h0;
        bad_q <= (bad_q == 4'hF) ? 4'hF : bad_q + 4'h1;
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  trs_follow_a: assert property (hit |-> ##1 trs_pulse)
    else $error("trs pulse missing");
  eav_sav_a: assert property (hit |-> ##1
    eav_pulse == $past(rx_word[6]) && sav_pulse != eav_pulse)
    else $error("eav or sav pulse wrong");
  lock_after_a: assert property (good_q == 2'h3 |=> mode_locked)
    else $error("no lock after good lines");
  lock_cause_a: assert property ($rose(mode_locked) |-> good_q == 2'h3)
    else $error("early lock");
  lock_hold_a: assert property (mode_locked && bad_q < 4'hE |=> mode_locked)
    else $error("lock lost too soon");
  lock_drop_a: assert property (bad_q == 4'hF |=> !mode_locked)
    else $error("lock kept after bad run");
  crc_report_a: assert property (stream_crc_stb |=>
    line_check_error_stream == $past(stream_crc_bad))
    else $error("stream errors wrong");
  mode_steady_a: assert property (mode_locked && $past(mode_locked) |-> $stable(rx_mode))
    else $error("mode moved while locked");
  family_set_a: assert property ($rose(t_locked) |-> t_family != 4'hF)
    else $error("no family at transport lock");
  cover property ($rose(mode_locked));
  cover property ($fell(mode_locked));
  cover property ($rose(t_locked));
endmodule
bind sdimd_lock sdimd_lock_checker #(.LINE_TIMEOUT(LINE_TIMEOUT)) chk_i (.pclk(pclk),
  .presetn(presetn), .rx_word(rx_word), .stream_crc_bad(stream_crc_bad),
  .stream_crc_stb(stream_crc_stb), .rx_mode(rx_mode), .mode_locked(mode_locked),
  .t_locked(t_locked), .t_family(t_family), .eav_pulse(eav_pulse), .sav_pulse(sav_pulse),
  .trs_pulse(trs_pulse), .line_check_error_stream(line_check_error_stream));
`default_nettype wire

// ### test/sdimd_lock_test.sv
// self-checking bench for the sdi mode lock detector
`timescale 1ns/1ps
`default_nettype none
`include "sdimd_defines.vh"
module sdimd_lock_test;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] rx_word;
  logic [15:0] stream_crc_bad;
  logic stream_crc_stb;
  logic [2:0] rx_mode;
  logic mode_locked;
  logic t_locked;
  logic [3:0] t_family;
  logic [3:0] t_rate;
  logic t_scan;
  logic [15:0] line_check_error_stream;
  logic [2:0] order [6] = '{`SDIMD_M_3G, `SDIMD_M_6G, `SDIMD_M_12GA, `SDIMD_M_12GB,
    `SDIMD_M_SD, `SDIMD_M_HD};
  int errors;
  int check_count;
  sdimd_lock #(.LINE_TIMEOUT(64)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_word(rx_word), .stream_crc_bad(stream_crc_bad),
    .stream_crc_stb(stream_crc_stb), .rx_mode(rx_mode), .mode_locked(mode_locked),
    .t_locked(t_locked), .t_family(t_family), .t_rate(t_rate), .t_scan(t_scan), .eav_pulse(),
    .sav_pulse(), .trs_pulse(), .line_check_error_stream(line_check_error_stream));
  sdimd_src src (.pclk(pclk), .rx_word(rx_word), .stream_crc_bad(stream_crc_bad),
    .stream_crc_stb(stream_crc_stb));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // on reads d is the expected data; one idle edge follows each transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      give_verdict();
    end
    if (!w) chk("read data", d, prdata);
    chk("slave error", {31'h0, e}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic next_mode(input logic [2:0] exp);
    logic [2:0] was;
    int n;
    was = rx_mode;
    n = 0;
    while (rx_mode === was && n < 300) begin
      src.fill(1);
      n++;
    end
    if (n >= 300) begin
      errors++;
      give_verdict();
    end
    chk("hunt mode", {29'h0, exp}, {29'h0, rx_mode});
  endtask
  initial begin
    errors = 0;
    check_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `SDIMD_REG_CTRL, 32'h0000013F, 1'b0);
    apb(1'b0, `SDIMD_REG_STAT, 32'h00001FE0, 1'b0);
    apb(1'b0, 8'h0C, 32'h00000000, 1'b1);
    $display("test reset over");
    repeat (2) src.line(1'b0, 16'h0000);
    chk("locked", 32'h0, {31'h0, mode_locked});
    src.line(1'b0, 16'h0000);
    chk("locked", 32'h1, {31'h0, mode_locked});
    chk("mode", {29'h0, `SDIMD_M_HD}, {29'h0, rx_mode});
    repeat (14) src.line(1'b0, 16'h8001);
    src.line(1'b0, 16'h0000);
    repeat (14) src.line(1'b0, 16'h8001);
    chk("locked", 32'h1, {31'h0, mode_locked});
    chk("stream errors", 32'h8001, {16'h0, line_check_error_stream});
    src.line(1'b0, 16'h0001);
    chk("locked", 32'h0, {31'h0, mode_locked});
    apb(1'b0, `SDIMD_REG_ERR, 32'h00000001, 1'b0);
    $display("test lock over");
    foreach (order[i]) next_mode(order[i]);
    apb(1'b1, `SDIMD_REG_CTRL, 32'h00000122, 1'b0);
    next_mode(`SDIMD_M_3G);
    next_mode(`SDIMD_M_SD);
    next_mode(`SDIMD_M_3G);
    apb(1'b0, `SDIMD_REG_CTRL, 32'h00000122, 1'b0);
    $display("test hunt over");
    apb(1'b1, `SDIMD_REG_CTRL, 32'h0000013F, 1'b0);
    for (int f = 0; f < 3; f++) begin
      for (int n = 0; n < `SDIMD_LINES_525; n++) begin
        src.line(n >= 520, 16'h0000);
      end
    end
    repeat (3) src.line(1'b1, 16'h0000);
    chk("t locked", 32'h1, {31'h0, t_locked});
    chk("family", {28'h0, `SDIMD_FAM_525}, {28'h0, t_family});
    chk("scan", 32'h0, {31'h0, t_scan});
    // 525 lines of 13 cycles make a frame far below the first rate threshold
    chk("rate", {28'h0, `SDIMD_RATE_60}, {28'h0, t_rate});
    $display("test transport over");
    give_verdict();
  end
endmodule
`default_nettype wire

// ### test/sdimd_src.sv
// word source standing in for the receive transceiver
`timescale 1ns/1ps
`default_nettype none
module sdimd_src (
  input wire logic pclk,
  output logic [9:0] rx_word,
  output logic [15:0] stream_crc_bad,
  output logic stream_crc_stb
);
  logic [9:0] fill_q = 10'h040;
  initial begin
    rx_word = 10'h040;
    stream_crc_bad = 16'h0000;
    stream_crc_stb = 1'b0;
  end
  task automatic put(input logic [9:0] w);
    rx_word <= w;
    stream_crc_stb <= 1'b0;
    @(posedge pclk);
  endtask
  // filler toggles so a stale word never looks held
  task automatic fill(input int n);
    repeat (n) begin
      fill_q = fill_q ^ 10'h0FF;
      put(fill_q);
    end
  endtask
  task automatic trs(input logic v, input logic h);
    put(10'h3FF);
    put(10'h000);
    put(10'h000);
    put({1'b1, 1'b0, v, h, v ^ h, h, v, v ^ h, 2'b00});
  endtask
  task automatic line(input logic v, input logic [15:0] bad);
    trs(v, 1'b1);
    stream_crc_bad <= bad;
    stream_crc_stb <= 1'b1;
    fill_q = fill_q ^ 10'h0FF;
    rx_word <= fill_q;
    @(posedge pclk);
    fill(2);
    trs(v, 1'b0);
    fill(2);
  endtask
endmodule
`default_nettype wire
